// >>> common/sfex_pkg.sv
// Purpose: Constants and types shared by the vector floating-point exception unit.
// Assumes: Single-precision operands, 32-bit APB register bus.
// Notes: Offsets are byte addresses of aligned words.
package sfex_pkg;
  localparam logic [11:0] ADDR_VCSR = 12'h000;
  localparam logic [11:0] ADDR_CTL_FOUR = 12'h004;
  localparam logic [11:0] ADDR_LAST = 12'h008;
  localparam logic [11:0] ADDR_RESTORE = 12'h00c;
  localparam int FLAG_INVALID = 0;
  localparam int FLAG_DENORMAL = 1;
  localparam int FLAG_DIVZERO = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_UNDERFLOW = 4;
  localparam int FLAG_INEXACT = 5;
  localparam int BIT_DAZ = 6;
  localparam int MASK_LSB = 7;
  localparam int BIT_FTZ = 15;
  localparam int CTL_FOUR_OS_SUPPORT = 10;
  localparam logic [31:0] VCSR_RESET = 32'h0000_1f80;
  localparam logic [31:0] VCSR_WMASK = 32'h0000_ffff;
  localparam logic [31:0] CTL_FOUR_WMASK = 32'h0000_0400;
  localparam logic [31:0] QNAN_INDEF = 32'hffc0_0000;
  localparam logic [31:0] INT_INDEF = 32'h8000_0000;
  localparam logic [31:0] INT_MIN_FP = 32'hcf00_0000;
  localparam logic [7:0] EXP_INT_LIMIT = 8'h9e;
  localparam logic [22:0] QUIET_BIT = 23'h40_0000;
  localparam logic [2:0] CF_UNORDERED = 3'h7;
  localparam logic [2:0] PRED_LT = 3'h1;
  localparam logic [2:0] PRED_LE = 3'h2;
  localparam logic [2:0] PRED_UNORD = 3'h3;
  localparam logic [2:0] PRED_NEQ = 3'h4;
  localparam logic [2:0] PRED_NLT = 3'h5;
  localparam logic [2:0] PRED_NLE = 3'h6;
  typedef enum logic [3:0] {
    SFEX_OP_INT, SFEX_OP_ADD, SFEX_OP_SUB, SFEX_OP_MUL, SFEX_OP_DIV, SFEX_OP_HORIZ,
    SFEX_OP_SQRT, SFEX_OP_MAXMIN, SFEX_OP_CMP, SFEX_OP_COMI, SFEX_OP_CVTFP,
    SFEX_OP_CVTINT, SFEX_OP_TRUNC_ISTORE
  } sfex_op_t;
endpackage : sfex_pkg

// >>> rtl/sfex_unit.sv
// Purpose: Vector floating-point exception detection, flags, masks and trap choice.
// Assumes: Datapath presents one operation per op_valid pulse with its post-computation
//   conditions; all inputs are on pclk.
// Notes: Answers one cycle after op_valid; APB slave answers in one wait state.
//
// Summary of operation
// - Packed integer operations never raise numeric exceptions.
// - Six classes detected: invalid, divide-by-zero, denormal, overflow, underflow, inexact.
// - Exceptions are reported at completion of the faulting operation itself.
// - Each class has one flag and one mask in the control/status register.
// - Load and restore write masks; store and save read masks and flags.
// - Unmasked exception with OS support bit 10 set raises the vector trap.
// - With OS support clear, the faulting vector instruction raises invalid-opcode instead.
// - Truncating integer store never raises vector floating-point exceptions.
// - Invalid flag at bit 0, invalid mask at bit 7.
// - Masked invalid result overwrites the instruction's destination register.
// - Masked invalid: signalling NaN is quieted and returned for arithmetic, sqrt, float-to-float conversions.
// - Masked invalid: sqrt of negative nonzero returns the quiet-NaN indefinite.
// - Masked invalid: max and min with any NaN return the second source.
// - Masked invalid: compares with NaN give zeros, ones for negated or unordered predicates.
// - Masked invalid: ordered flag compare with NaN sets not-comparable flags.
// - Masked invalid: infinity clashes and zero over zero return the indefinite.
// - Masked invalid: float-to-int of NaN, infinity or out of range gives integer indefinite.
// - Unmasked invalid leaves operands unchanged and writes no result.
// - Quiet NaN alone is not invalid, except ordered compares, relational predicates, max/min and float-to-int.
// - Invalid detection ignores flush-to-zero and denormals-are-zero settings.
// - Denormal flag at bit 1, mask at bit 8.
// - Divide-by-zero flag at bit 2, mask at bit 9.
// - Overflow flag at bit 3, mask at bit 10.
// - Underflow flag at bit 4, mask at bit 11.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
module sfex_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire sfex_pkg::sfex_op_t op_kind,
  input wire logic op_negate,
  input wire logic [2:0] cmp_pred,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic denormal_cond,
  input wire logic divzero_cond,
  input wire logic overflow_cond,
  input wire logic underflow_cond,
  input wire logic inexact_cond,
  output logic done_valid,
  output logic result_override,
  output logic [31:0] result_value,
  output logic result_suppress,
  output logic flags_valid,
  output logic [2:0] cond_flags,
  output logic vector_fp_trap,
  output logic invalid_opcode_fault
);
  import sfex_pkg::*;

  function automatic logic is_nan(input logic [31:0] v);
    return (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
  endfunction : is_nan
  function automatic logic is_snan(input logic [31:0] v);
    return is_nan(v) && !v[22];
  endfunction : is_snan
  function automatic logic is_inf(input logic [31:0] v);
    return (v[30:23] == 8'hff) && (v[22:0] == 23'h0);
  endfunction : is_inf
  function automatic logic is_zero(input logic [31:0] v);
    return v[30:0] == 31'h0;
  endfunction : is_zero
  function automatic logic [31:0] quieten(input logic [31:0] v);
    return {v[31:23], v[22:0] | QUIET_BIT};
  endfunction : quieten

  logic [31:0] vcsr_q;
  logic [31:0] vcsr_d;
  logic [31:0] ctl_four_q;
  logic [5:0] last_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic done_q;
  logic override_q;
  logic [31:0] result_q;
  logic suppress_q;
  logic flags_valid_q;
  logic [2:0] cond_q;
  logic trap_q;
  logic fault_q;

  logic apb_access;
  logic apb_commit;
  logic addr_ok;
  logic [31:0] rd_word;
  logic any_nan;
  logic any_snan;
  logic inv;
  logic inv_override;
  logic [31:0] inv_value;
  logic inv_flags;
  logic fp_op;
  logic [5:0] cond_vec;
  logic [5:0] masks;
  logic unmasked;
  logic os_support;

  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready_q;
  assign addr_ok = (paddr == ADDR_VCSR) || (paddr == ADDR_CTL_FOUR) ||
                   (paddr == ADDR_LAST) || (paddr == ADDR_RESTORE);
  assign masks = vcsr_q[MASK_LSB +: 6];
  assign os_support = ctl_four_q[CTL_FOUR_OS_SUPPORT];
  assign any_nan = is_nan(op_a) || is_nan(op_b);
  assign any_snan = is_snan(op_a) || is_snan(op_b);

  // Only floating-point kinds may report; integer and truncating store are excluded
  assign fp_op = op_valid && (op_kind != SFEX_OP_INT) &&
                 (op_kind != SFEX_OP_TRUNC_ISTORE);

  // Invalid detection and masked responses; no use of flush or DAZ bits
  always_comb begin
    inv = 1'b0;
    inv_override = 1'b0;
    inv_value = 32'h0;
    inv_flags = 1'b0;
    unique case (op_kind)
      SFEX_OP_ADD, SFEX_OP_SUB, SFEX_OP_HORIZ: begin
        if (any_snan) begin
          inv = 1'b1;
          inv_value = is_snan(op_a) ? quieten(op_a) : quieten(op_b);
        end else if (is_inf(op_a) && is_inf(op_b) &&
                     ((op_a[31] ^ op_b[31]) ^ (op_kind == SFEX_OP_SUB) ^ op_negate)) begin
          inv = 1'b1;
          inv_value = QNAN_INDEF;
        end
      end
      SFEX_OP_MUL: begin
        if (any_snan) begin
          inv = 1'b1;
          inv_value = is_snan(op_a) ? quieten(op_a) : quieten(op_b);
        end else if ((is_inf(op_a) && is_zero(op_b)) || (is_zero(op_a) && is_inf(op_b))) begin
          inv = 1'b1;
          inv_value = QNAN_INDEF;
        end
      end
      SFEX_OP_DIV: begin
        if (any_snan) begin
          inv = 1'b1;
          inv_value = is_snan(op_a) ? quieten(op_a) : quieten(op_b);
        end else if ((is_zero(op_a) && is_zero(op_b)) || (is_inf(op_a) && is_inf(op_b))) begin
          inv = 1'b1;
          inv_value = QNAN_INDEF;
        end
      end
      SFEX_OP_SQRT: begin
        if (is_snan(op_a)) begin
          inv = 1'b1;
          inv_value = quieten(op_a);
        end else if (op_a[31] && !is_zero(op_a) && !is_nan(op_a)) begin
          inv = 1'b1;
          inv_value = QNAN_INDEF;
        end
      end
      SFEX_OP_CVTFP: begin
        if (is_snan(op_a)) begin
          inv = 1'b1;
          inv_value = quieten(op_a);
        end
      end
      SFEX_OP_MAXMIN: begin
        if (any_nan) begin
          inv = 1'b1;
          inv_value = op_b;
        end
      end
      SFEX_OP_CMP: begin
        if (any_nan) begin
          inv_override = 1'b1;
          inv_value = ((cmp_pred == PRED_NEQ) || (cmp_pred == PRED_UNORD) ||
                       (cmp_pred == PRED_NLT) || (cmp_pred == PRED_NLE)) ? 32'hffff_ffff : 32'h0;
          inv = any_snan || (cmp_pred == PRED_LT) || (cmp_pred == PRED_LE) ||
                (cmp_pred == PRED_NLT) || (cmp_pred == PRED_NLE);
        end
      end
      SFEX_OP_COMI: begin
        if (any_nan) begin
          inv = 1'b1;
          inv_flags = 1'b1;
        end
      end
      SFEX_OP_CVTINT: begin
        if (is_nan(op_a) || (op_a[30:23] >= EXP_INT_LIMIT && op_a != INT_MIN_FP)) begin
          inv = 1'b1;
          inv_value = INT_INDEF;
        end
      end
      default: begin
      end
    endcase
  end

  // Masked underflow is only reported together with inexact
  assign cond_vec = fp_op ? {inexact_cond,
                             underflow_cond && (inexact_cond || !masks[FLAG_UNDERFLOW]),
                             overflow_cond, divzero_cond, denormal_cond, inv} : 6'h0;
  assign unmasked = |(cond_vec & ~masks);

  always_comb begin
    unique case (paddr)
      ADDR_VCSR, ADDR_RESTORE: rd_word = vcsr_q;
      ADDR_CTL_FOUR: rd_word = ctl_four_q;
      ADDR_LAST: rd_word = {26'h0, last_q};
      default: rd_word = 32'h0;
    endcase
  end

  // Newly detected conditions win over a software write in the same cycle
  always_comb begin
    vcsr_d = vcsr_q;
    if (apb_commit && pwrite && addr_ok && (paddr == ADDR_VCSR || paddr == ADDR_RESTORE)) begin
      vcsr_d = pwdata & VCSR_WMASK;
    end
    vcsr_d[5:0] = vcsr_d[5:0] | cond_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcsr_q <= VCSR_RESET;
    end else begin
      vcsr_q <= vcsr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_four_q <= 32'h0;
      last_q <= 6'h0;
    end else begin
      if (apb_commit && pwrite && paddr == ADDR_CTL_FOUR) begin
        ctl_four_q <= pwdata & CTL_FOUR_WMASK;
      end
      if (fp_op) begin
        last_q <= cond_vec;
      end
    end
  end

  // APB slave: one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_access && !pready_q;
      pslverr_q <= apb_access && !pready_q && !addr_ok;
      if (apb_access && !pready_q && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  // Completion outputs, registered one cycle after the operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      override_q <= 1'b0;
      result_q <= 32'h0;
      suppress_q <= 1'b0;
      flags_valid_q <= 1'b0;
      cond_q <= 3'h0;
      trap_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      done_q <= op_valid;
      override_q <= fp_op && (inv || inv_override) && !inv_flags && masks[FLAG_INVALID];
      result_q <= inv_value;
      suppress_q <= fp_op && unmasked;
      flags_valid_q <= fp_op && inv_flags && masks[FLAG_INVALID];
      cond_q <= (fp_op && inv_flags) ? CF_UNORDERED : cond_q;
      trap_q <= fp_op && unmasked && os_support;
      fault_q <= fp_op && unmasked && !os_support;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign done_valid = done_q;
  assign result_override = override_q;
  assign result_value = result_q;
  assign result_suppress = suppress_q;
  assign flags_valid = flags_valid_q;
  assign cond_flags = cond_q;
  assign vector_fp_trap = trap_q;
  assign invalid_opcode_fault = fault_q;

  property p_int_quiet;
    @(posedge pclk) disable iff (!presetn)
      (op_valid && (op_kind == SFEX_OP_INT || op_kind == SFEX_OP_TRUNC_ISTORE))
      |=> !vector_fp_trap && !invalid_opcode_fault && !result_suppress;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("integer op raised exception");
  property p_trap_os;
    @(posedge pclk) disable iff (!presetn)
      (fp_op && unmasked && os_support) |=> vector_fp_trap && !invalid_opcode_fault;
  endproperty
  a_trap_os: assert property (p_trap_os) else $error("vector trap missing");
  property p_fault_no_os;
    @(posedge pclk) disable iff (!presetn)
      (fp_op && unmasked && !os_support) |=> invalid_opcode_fault && !vector_fp_trap;
  endproperty
  a_fault_no_os: assert property (p_fault_no_os) else $error("invalid opcode missing");
  property p_trap_cause;
    @(posedge pclk) disable iff (!presetn)
      (vector_fp_trap || invalid_opcode_fault) |-> $past(op_valid) && result_suppress;
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without operation");
  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (vcsr_q[FLAG_INVALID] && !(apb_commit && pwrite)) |=> vcsr_q[FLAG_INVALID];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("invalid flag lost");
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (fp_op && inv) |=> vcsr_q[FLAG_INVALID];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("invalid flag not set");
  property p_sqrt_neg;
    @(posedge pclk) disable iff (!presetn)
      (op_valid && op_kind == SFEX_OP_SQRT && op_a[31] && !is_zero(op_a) && !is_nan(op_a) &&
       masks[FLAG_INVALID]) |=> result_override && result_value == QNAN_INDEF;
  endproperty
  a_sqrt_neg: assert property (p_sqrt_neg) else $error("sqrt indefinite wrong");
  property p_maxmin;
    @(posedge pclk) disable iff (!presetn)
      (op_valid && op_kind == SFEX_OP_MAXMIN && any_nan && masks[FLAG_INVALID])
      |=> result_override && result_value == $past(op_b);
  endproperty
  a_maxmin: assert property (p_maxmin) else $error("max/min source 2 wrong");
  property p_qnan_add;
    @(posedge pclk) disable iff (!presetn)
      (op_valid && op_kind == SFEX_OP_ADD && any_nan && !any_snan) |=> !last_q[FLAG_INVALID];
  endproperty
  a_qnan_add: assert property (p_qnan_add) else $error("quiet NaN raised invalid");
  property p_unmasked_nowrite;
    @(posedge pclk) disable iff (!presetn)
      (fp_op && inv && !masks[FLAG_INVALID]) |=> result_suppress && !result_override;
  endproperty
  a_unmasked_nowrite: assert property (p_unmasked_nowrite) else $error("unmasked wrote");
  property p_apb_one_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb wait state wrong");
  c_trap: cover property (@(posedge pclk) disable iff (!presetn) vector_fp_trap);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) invalid_opcode_fault);
  c_masked: cover property (@(posedge pclk) disable iff (!presetn) result_override);
  c_comi: cover property (@(posedge pclk) disable iff (!presetn) flags_valid);
endmodule : sfex_unit

// >>> sim/sfex_dp_model.sv
// Purpose: Datapath and trap-sequencer stand-in that issues operations to the exception unit.
// Assumes: One operation per call, answers sampled one cycle after op_valid.
// Notes: Between operations the operand and condition lines carry inverted junk.
`timescale 1ns/10ps
module sfex_dp_model (
  input wire logic pclk,
  output logic op_valid,
  output sfex_pkg::sfex_op_t op_kind,
  output logic op_negate,
  output logic [2:0] cmp_pred,
  output logic [31:0] op_a,
  output logic [31:0] op_b,
  output logic denormal_cond,
  output logic divzero_cond,
  output logic overflow_cond,
  output logic underflow_cond,
  output logic inexact_cond,
  input wire logic done_valid,
  input wire logic result_override,
  input wire logic [31:0] result_value,
  input wire logic result_suppress,
  input wire logic flags_valid,
  input wire logic [2:0] cond_flags,
  input wire logic vector_fp_trap,
  input wire logic invalid_opcode_fault
);
  import sfex_pkg::*;
  logic m_done, m_ovr, m_sup, m_fv, m_trap, m_flt;
  logic [31:0] m_val;
  logic [2:0] m_cf;
  initial begin
    op_valid = 1'b0;
    op_kind = SFEX_OP_INT;
    op_negate = 1'b0;
    cmp_pred = 3'h0;
    op_a = 32'h0;
    op_b = 32'h0;
    {inexact_cond, underflow_cond, overflow_cond, divzero_cond, denormal_cond} = 5'h0;
  end
  task automatic issue(input sfex_op_t k, input logic ng, input logic [2:0] pr,
                       input logic [31:0] a, input logic [31:0] b, input logic [4:0] c);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_negate <= ng;
    cmp_pred <= pr;
    op_a <= a;
    op_b <= b;
    {inexact_cond, underflow_cond, overflow_cond, divzero_cond, denormal_cond} <= c;
    @(posedge pclk);
    op_valid <= 1'b0;
    op_a <= ~a;
    op_b <= ~b;
    {inexact_cond, underflow_cond, overflow_cond, divzero_cond, denormal_cond} <= ~c;
    @(posedge pclk);
    m_done = done_valid;
    m_ovr = result_override;
    m_val = result_value;
    m_sup = result_suppress;
    m_fv = flags_valid;
    m_cf = cond_flags;
    m_trap = vector_fp_trap;
    m_flt = invalid_opcode_fault;
  endtask : issue
endmodule : sfex_dp_model

// >>> sim/tb.sv
// Purpose: Self-checking bench for the vector floating-point exception unit.
// Assumes: APB master with one-cycle idle between transfers.
// Notes: Expected values follow the flag, mask and default-result encodings.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import sfex_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, op_a, op_b, result_value;
  logic op_valid, op_negate, denormal_cond, divzero_cond, overflow_cond, underflow_cond;
  logic inexact_cond, done_valid, result_override, result_suppress, flags_valid;
  logic vector_fp_trap, invalid_opcode_fault;
  logic [2:0] cmp_pred, cond_flags;
  sfex_op_t op_kind;
  int fails, n_compared;
  sfex_op_t tk [13] = '{SFEX_OP_ADD, SFEX_OP_SQRT, SFEX_OP_CVTFP, SFEX_OP_MAXMIN, SFEX_OP_MAXMIN,
    SFEX_OP_ADD, SFEX_OP_SUB, SFEX_OP_MUL, SFEX_OP_DIV, SFEX_OP_DIV, SFEX_OP_CVTINT,
    SFEX_OP_CVTINT, SFEX_OP_CVTINT};
  logic [31:0] ta [13] = '{32'h7f80_0001, 32'hff80_0001, 32'h7f80_0001, 32'h7fc0_0000,
    32'h3f80_0000, 32'h7f80_0000, 32'h7f80_0000, 32'h7f80_0000, 32'h0, 32'h7f80_0000,
    32'h7fc0_0000, 32'hff80_0000, 32'h4f00_0000};
  logic [31:0] tb2 [13] = '{32'h3f80_0000, 32'h0, 32'h0, 32'h3f80_0000, 32'h7f80_0001,
    32'hff80_0000, 32'h7f80_0000, 32'h0, 32'h0, 32'h7f80_0000, 32'h0, 32'h0, 32'h0};
  logic [31:0] te [13] = '{32'h7fc0_0001, 32'hffc0_0001, 32'h7fc0_0001, 32'h3f80_0000,
    32'h7f80_0001, QNAN_INDEF, QNAN_INDEF, QNAN_INDEF, QNAN_INDEF, QNAN_INDEF, INT_INDEF,
    INT_INDEF, INT_INDEF};
  always #20 pclk = ~pclk;
  sfex_unit sfex_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_kind, .op_negate, .cmp_pred, .op_a, .op_b, .denormal_cond,
    .divzero_cond, .overflow_cond, .underflow_cond, .inexact_cond, .done_valid,
    .result_override, .result_value, .result_suppress, .flags_valid, .cond_flags,
    .vector_fp_trap, .invalid_opcode_fault);
  sfex_dp_model sfex_dp_model_i (.pclk, .op_valid, .op_kind, .op_negate, .cmp_pred, .op_a,
    .op_b, .denormal_cond, .divzero_cond, .overflow_cond, .underflow_cond, .inexact_cond,
    .done_valid, .result_override, .result_value, .result_suppress, .flags_valid,
    .cond_flags, .vector_fp_trap, .invalid_opcode_fault);
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask : apb
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input string nm);
    apb(1'b0, ad, 32'h0);
    `CHK(nm, e, rdat)
  endtask : rd
  // Issues one operation; an x in eo skips the override check
  task automatic op_chk(input sfex_op_t k, input logic [2:0] pr, input logic [31:0] a,
    input logic [31:0] b, input logic [4:0] c, input logic eo, input logic [31:0] ev,
    input logic et, input logic ef);
    sfex_dp_model_i.issue(k, 1'b0, pr, a, b, c);
    `CHK("done", 1'b1, sfex_dp_model_i.m_done)
    if (eo !== 1'bx) `CHK("override", eo, sfex_dp_model_i.m_ovr)
    if (eo === 1'b1) `CHK("value", ev, sfex_dp_model_i.m_val)
    `CHK("trap", et, sfex_dp_model_i.m_trap)
    `CHK("fault", ef, sfex_dp_model_i.m_flt)
    `CHK("suppress", et | ef, sfex_dp_model_i.m_sup)
  endtask : op_chk
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_VCSR, VCSR_RESET, "vcsr_reset");
    rd(ADDR_CTL_FOUR, 32'h0, "ctl_four_reset");
    rd(12'h010, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, rerr)
    $display("test reset done");
    apb(1'b1, ADDR_VCSR, 32'h0000_9fc0);
    rd(ADDR_RESTORE, 32'h0000_9fc0, "restore_alias");
    op_chk(SFEX_OP_SQRT, 0, 32'hbf80_0000, 0, 0, 1, QNAN_INDEF, 0, 0);
    rd(ADDR_VCSR, 32'h0000_9fc1, "invalid_flag");
    op_chk(SFEX_OP_ADD, 0, 32'h3f80_0000, 32'h3f80_0000, 0, 0, 0, 0, 0);
    rd(ADDR_VCSR, 32'h0000_9fc1, "sticky");
    apb(1'b1, ADDR_VCSR, 32'h0000_1f80);
    for (int i = 0; i < 13; i++) begin
      op_chk(tk[i], 0, ta[i], tb2[i], 0, 1, te[i], 0, 0);
    end
    op_chk(SFEX_OP_CVTINT, 0, INT_MIN_FP, 0, 0, 0, 0, 0, 0);
    sfex_dp_model_i.issue(SFEX_OP_HORIZ, 1'b1, 3'h0, 32'h7f80_0000, 32'h7f80_0000, 5'h0);
    `CHK("horiz_ovr", 1'b1, sfex_dp_model_i.m_ovr)
    `CHK("horiz_value", QNAN_INDEF, sfex_dp_model_i.m_val)
    sfex_dp_model_i.issue(SFEX_OP_COMI, 1'b0, 3'h0, 32'h7fc0_0000, 32'h0, 5'h0);
    `CHK("flags_valid", 1'b1, sfex_dp_model_i.m_fv)
    `CHK("cond_flags", CF_UNORDERED, sfex_dp_model_i.m_cf)
    for (int p = 0; p < 8; p++) begin
      op_chk(SFEX_OP_CMP, p[2:0], 32'h7fc0_0000, 0, 0, 1,
        (p inside {PRED_UNORD, PRED_NEQ, PRED_NLT, PRED_NLE}) ? 32'hffff_ffff : 32'h0, 0, 0);
    end
    $display("test masked_invalid done");
    apb(1'b1, ADDR_VCSR, 32'h0000_1f00);
    apb(1'b1, ADDR_CTL_FOUR, 32'h0000_0400);
    op_chk(SFEX_OP_SQRT, 0, 32'hbf80_0000, 0, 0, 0, 0, 1, 0);
    op_chk(SFEX_OP_ADD, 0, 32'h7fc0_0000, 32'h3f80_0000, 0, 1'bx, 0, 0, 0);
    op_chk(SFEX_OP_CMP, PRED_NEQ, 32'h7fc0_0000, 0, 0, 1'bx, 0, 0, 0);
    op_chk(SFEX_OP_CMP, PRED_LT, 32'h7fc0_0000, 0, 0, 1'bx, 0, 1, 0);
    op_chk(SFEX_OP_COMI, 0, 32'h7fc0_0000, 0, 0, 1'bx, 0, 1, 0);
    op_chk(SFEX_OP_INT, 0, 32'h7f80_0001, 32'h7f80_0001, 5'h1f, 0, 0, 0, 0);
    op_chk(SFEX_OP_TRUNC_ISTORE, 0, 32'h7f80_0001, 0, 5'h1f, 0, 0, 0, 0);
    apb(1'b1, ADDR_CTL_FOUR, 32'h0);
    op_chk(SFEX_OP_SQRT, 0, 32'hbf80_0000, 0, 0, 0, 0, 0, 1);
    apb(1'b1, ADDR_CTL_FOUR, 32'h0000_0400);
    $display("test unmasked_invalid done");
    for (int i = 1; i < 6; i++) begin
      apb(1'b1, ADDR_VCSR, 32'h0000_1f80 & ~(32'h1 << (MASK_LSB + i)));
      op_chk(SFEX_OP_ADD, 0, 32'h3f80_0000, 0, 5'h1 << (i - 1), 0, 0, 1, 0);
      op_chk(SFEX_OP_ADD, 0, 32'h3f80_0000, 0, (i == 5) ? 5'h01 : 5'h10, 0, 0, 0, 0);
      rd(ADDR_VCSR, (32'h0000_1f80 & ~(32'h1 << (MASK_LSB + i))) | (32'h1 << i) |
        ((i == 5) ? 32'h2 : 32'h20), "class_flags");
      rd(ADDR_LAST, (i == 5) ? 32'h2 : 32'h20, "last_conds");
    end
    $display("test exception_classes done");
    test_done();
  end
endmodule : tb
